// ==== hdl/ecp_coding_path.sv ====
// ecp_coding_path: 100 Mb/s receive coding and 10 Mb/s transmit/receive coding
// assumes rx100 bits arrive from core_clk logic; 10 Mb/s line inputs are asynchronous
// How it works
// - on idle, descrambler key loads from stream, then runs free once locked
// - no idle within 40 us window aborts reception and restarts synchronisation
// - bypass input passes received bits straight through, no descrambling
// - start delimiter pair fixes 5-bit boundaries until the frame ends
// - start pair yields two 0101 nibbles, later data groups their nibbles
// - start delimiter pair asserts receive data valid
// - end pair or two idles drop carrier and valid, emit no nibble
// - invalid group while valid asserts receive error
// - first end symbol not followed by second one asserts receive error
// - MAC nibbles with enable are captured at rising transmit clock
// - captured nibbles are serialised and Manchester encoded at 20 MHz
// - with enable low, normal link pulses are sent instead of data
// - received Manchester is checked and reversed polarity corrected
// - reversed polarity sets the polarity reversed flag
// - received bits are packed into nibbles delivered at 2.5 MHz
// - link pulses received while idle keep the receive link up
// - enable held past jabber limit aborts transmission within 45 ms
// - jabber clears as soon as enable drops
`timescale 1ns/1ps
`default_nettype none
module ecp_coding_path #(
  parameter int JABBER_CYC = ecp_pkg::JABBER_CYC,
  parameter int NLP_PERIOD_CYC = ecp_pkg::NLP_PERIOD_CYC,
  parameter int LINK_FAIL_CYC = ecp_pkg::LINK_FAIL_CYC
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // 100 Mb/s receive bit stream and control
  input wire logic rx100_bit_i,
  input wire logic rx100_bit_vld_i,
  input wire logic descr_bypass_i,
  // 100 Mb/s receive nibble side
  output logic [3:0] rx100_nib_o,
  output logic rx100_nib_vld_o,
  output logic rx100_dv_o,
  output logic rx100_er_o,
  output logic rx100_crs_o,
  output logic rx100_locked_o,
  // 10 Mb/s MAC transmit side
  output logic tx_clk_o,
  input wire logic tx_en_i,
  input wire logic [3:0] txd_i,
  output logic jabber_o,
  // 10 Mb/s line transmit
  output logic tx10_data_o,
  output logic tx10_drive_o,
  // 10 Mb/s line receive
  input wire logic rx10_line_i,
  input wire logic rx10_active_i,
  output logic [3:0] rx10_nib_o,
  output logic rx10_nib_vld_o,
  output logic rx10_dv_o,
  output logic rx10_code_err_o,
  output logic polarity_reversed_flag_o,
  output logic rx10_link_o
);
  localparam int JW = $clog2(JABBER_CYC + 1);
  localparam int NW = $clog2(NLP_PERIOD_CYC + 1);
  localparam int LW = $clog2(LINK_FAIL_CYC + 1);
  localparam int WW = $clog2(ecp_pkg::SYNC_WIN_CYC + 1);

  if (JABBER_CYC < 2 || NLP_PERIOD_CYC < 4 || LINK_FAIL_CYC < 2)
  begin : g_chk
    $error("ecp_coding_path: timing counts too small");
  end

  ecp_dec_if dif ();
  ecp_decoder u_dec (.dec(dif));

  // descrambler and sync state
  logic [10:0] lfsr, next_lfsr;
  logic locked, next_locked;
  logic [5:0] chk_cnt, next_chk_cnt;
  logic [3:0] ones_run, next_ones_run;
  logic [WW-1:0] win_cnt, next_win_cnt;
  logic key, dbit, dbit_vld, sync_abort;

  // key prediction, bypass and descrambled bit
  assign key = lfsr[10] ^ lfsr[8];
  assign dbit = descr_bypass_i ? rx100_bit_i : (rx100_bit_i ^ key);
  assign dbit_vld = rx100_bit_vld_i && (locked || descr_bypass_i);
  assign sync_abort = locked && !descr_bypass_i && (win_cnt == WW'(ecp_pkg::SYNC_WIN_CYC));

  // hunt loads inverted idle bits as key, lock lets the key run
  always_comb
  begin
    next_lfsr = lfsr;
    next_locked = locked;
    next_chk_cnt = chk_cnt;
    next_ones_run = ones_run;
    next_win_cnt = win_cnt;
    if (!locked && rx100_bit_vld_i)
    begin
      next_lfsr = {lfsr[9:0], ~rx100_bit_i};
      if (chk_cnt < 6'(ecp_pkg::LFSR_W) || key == ~rx100_bit_i)
        next_chk_cnt = chk_cnt + 6'h01;
      else
        next_chk_cnt = 6'h00;
      if (chk_cnt == 6'(ecp_pkg::LFSR_W + ecp_pkg::SYNC_CHECK_BITS - 1) && key == ~rx100_bit_i)
        next_locked = 1'b1;
    end
    else if (locked && rx100_bit_vld_i)
      next_lfsr = {lfsr[9:0], key};
    if (locked)
      next_win_cnt = win_cnt + WW'(1);
    if (dbit_vld)
    begin
      next_ones_run = dbit ? ((ones_run == 4'(ecp_pkg::IDLE_RUN_BITS)) ? ones_run : ones_run + 4'h1)
                           : 4'h0;
      if (ones_run == 4'(ecp_pkg::IDLE_RUN_BITS - 1) && dbit)
        next_win_cnt = '0;
    end
    if (sync_abort)
    begin
      next_locked = 1'b0;
      next_chk_cnt = 6'h00;
      next_win_cnt = '0;
      next_ones_run = 4'h0;
    end
  end

  // descrambler registers
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      lfsr <= 11'h000;
      locked <= 1'b0;
      chk_cnt <= 6'h00;
      ones_run <= 4'h0;
      win_cnt <= '0;
    end
    else
    begin
      lfsr <= next_lfsr;
      locked <= next_locked;
      chk_cnt <= next_chk_cnt;
      ones_run <= next_ones_run;
      win_cnt <= next_win_cnt;
    end
  end

  // alignment and 5b/4b frame state
  ecp_pkg::ecp_rx_e st, next_st;
  logic [9:0] sr, next_sr;
  logic [2:0] bcnt, next_bcnt;
  logic pre2, next_pre2;
  logic [3:0] nib, next_nib;
  logic nib_vld, next_nib_vld, er, next_er;
  logic ssd_hit, grp_done, end_hit;
  logic [9:0] sr_in;

  assign sr_in = {sr[8:0], dbit};
  assign dif.code = sr_in[4:0];
  assign ssd_hit = dbit_vld && st == ecp_pkg::ECP_RX_IDLE && sr_in == ecp_pkg::SSD_PAIR;
  assign grp_done = dbit_vld && st != ecp_pkg::ECP_RX_IDLE && bcnt == 3'h4;
  assign end_hit = grp_done && ((st == ecp_pkg::ECP_RX_GOT_T && dif.is_r) ||
                                (st == ecp_pkg::ECP_RX_GOT_I && dif.is_idle));

  // delimiter hunt, per-group decode and frame end
  always_comb
  begin
    next_st = st;
    next_sr = dbit_vld ? sr_in : sr;
    next_bcnt = bcnt;
    next_pre2 = 1'b0;
    next_nib = nib;
    next_nib_vld = 1'b0;
    next_er = 1'b0;
    if (dbit_vld && st != ecp_pkg::ECP_RX_IDLE)
      next_bcnt = (bcnt == 3'h4) ? 3'h0 : bcnt + 3'h1;
    if (pre2)
    begin
      next_nib = ecp_pkg::PREAMBLE_NIB;
      next_nib_vld = 1'b1;
    end
    if (ssd_hit)
    begin
      next_st = ecp_pkg::ECP_RX_DATA;
      next_bcnt = 3'h0;
      next_nib = ecp_pkg::PREAMBLE_NIB;
      next_nib_vld = 1'b1;
      next_pre2 = 1'b1;
    end
    else if (grp_done)
    begin
      case (st)
        ecp_pkg::ECP_RX_GOT_T:
        begin
          if (dif.is_r)
            next_st = ecp_pkg::ECP_RX_IDLE;
          else
          begin
            next_er = 1'b1;
            next_st = ecp_pkg::ECP_RX_DATA;
          end
        end
        ecp_pkg::ECP_RX_GOT_I:
        begin
          if (dif.is_idle)
            next_st = ecp_pkg::ECP_RX_IDLE;
          else
          begin
            next_er = 1'b1;
            next_st = ecp_pkg::ECP_RX_DATA;
          end
        end
        default:
        begin
          if (dif.is_t)
            next_st = ecp_pkg::ECP_RX_GOT_T;
          else if (dif.is_idle)
            next_st = ecp_pkg::ECP_RX_GOT_I;
          else
          begin
            next_nib = dif.nibble;
            next_nib_vld = 1'b1;
            next_er = !dif.is_data;
          end
        end
      endcase
    end
    if (sync_abort)
    begin
      next_st = ecp_pkg::ECP_RX_IDLE;
      next_nib_vld = 1'b0;
      next_pre2 = 1'b0;
      next_er = 1'b0;
    end
  end

  // frame registers
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st <= ecp_pkg::ECP_RX_IDLE;
      sr <= 10'h000;
      bcnt <= 3'h0;
      pre2 <= 1'b0;
      nib <= 4'h0;
      nib_vld <= 1'b0;
      er <= 1'b0;
    end
    else
    begin
      st <= next_st;
      sr <= next_sr;
      bcnt <= next_bcnt;
      pre2 <= next_pre2;
      nib <= next_nib;
      nib_vld <= next_nib_vld;
      er <= next_er;
    end
  end

  // 100 Mb/s outputs, carrier and valid follow the frame state
  assign rx100_nib_o = nib;
  assign rx100_nib_vld_o = nib_vld;
  assign rx100_er_o = er;
  assign rx100_dv_o = (st != ecp_pkg::ECP_RX_IDLE);
  assign rx100_crs_o = (st != ecp_pkg::ECP_RX_IDLE);
  assign rx100_locked_o = locked || descr_bypass_i;

  // 10 Mb/s transmit: clock divider, capture, Manchester, link pulses, jabber
  logic [2:0] div, next_div, ph, next_ph;
  logic [3:0] tsh, next_tsh;
  logic tact, next_tact, jab, next_jab, tdat, next_tdat, tdrv, next_tdrv;
  logic [JW-1:0] jcnt, next_jcnt;
  logic [NW-1:0] ncnt, next_ncnt;
  logic cap, tbit;

  assign cap = (div == 3'(ecp_pkg::TXCLK_DIV / 2 - 1)); // tx_clk rises on this edge
  assign tbit = tsh[ph[2:1]];

  always_comb
  begin
    next_div = div + 3'h1;
    next_ph = ph + 3'h1;
    next_tsh = tsh;
    next_tact = tact;
    next_jab = jab;
    next_jcnt = jcnt;
    next_ncnt = ncnt;
    next_tdat = 1'b0;
    next_tdrv = 1'b0;
    if (!tx_en_i)
    begin
      next_jab = 1'b0;
      next_jcnt = '0;
    end
    else if (jcnt == JW'(JABBER_CYC - 1))
      next_jab = 1'b1;
    else
      next_jcnt = jcnt + JW'(1);
    if (cap)
    begin
      next_tact = tx_en_i && !next_jab;
      next_tsh = txd_i;
      next_ph = 3'h0;
    end
    if (tact && !jab)
    begin
      next_tdat = ph[0] ? tbit : ~tbit;
      next_tdrv = 1'b1;
      next_ncnt = '0;
    end
    else if (!tx_en_i)
    begin
      next_ncnt = (ncnt == NW'(NLP_PERIOD_CYC - 1)) ? '0 : ncnt + NW'(1);
      if (ncnt < NW'(ecp_pkg::NLP_PULSE_CYC))
      begin
        next_tdat = 1'b1;
        next_tdrv = 1'b1;
      end
    end
  end

  // transmit registers
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div <= 3'h0;
      ph <= 3'h0;
      tsh <= 4'h0;
      tact <= 1'b0;
      jab <= 1'b0;
      jcnt <= '0;
      ncnt <= '0;
      tdat <= 1'b0;
      tdrv <= 1'b0;
    end
    else
    begin
      div <= next_div;
      ph <= next_ph;
      tsh <= next_tsh;
      tact <= next_tact;
      jab <= next_jab;
      jcnt <= next_jcnt;
      ncnt <= next_ncnt;
      tdat <= next_tdat;
      tdrv <= next_tdrv;
    end
  end

  assign tx_clk_o = div[2];
  assign jabber_o = jab;
  assign tx10_data_o = tdat;
  assign tx10_drive_o = tdrv;

  // 10 Mb/s receive: synchronisers then Manchester decode
  logic [1:0] ln_s, act_s;
  logic ln_d, half, first, pol_inv, pol_known, rin, rbit, ce;
  logic next_ln_d, next_half, next_first, next_pol_inv, next_pol_known, next_rin, next_ce;
  logic [1:0] rbc, next_rbc;
  logic [3:0] rsh, next_rsh, rnib, next_rnib;
  logic rvld, next_rvld, pflag, next_pflag;
  logic [LW-1:0] lcnt, next_lcnt;

  assign rbit = ln_s[1] ^ pol_inv;

  always_comb
  begin
    next_ln_d = ln_s[1];
    next_rin = act_s[1];
    next_half = half;
    next_first = first;
    next_pol_inv = pol_inv;
    next_pol_known = pol_known;
    next_rbc = rbc;
    next_rsh = rsh;
    next_rnib = rnib;
    next_rvld = 1'b0;
    next_ce = 1'b0;
    next_pflag = pflag;
    next_lcnt = (lcnt == LW'(LINK_FAIL_CYC)) ? lcnt : lcnt + LW'(1);
    if (act_s[1] && !rin)
    begin
      next_half = 1'b1; // the sample at frame start is half 0
      next_first = ln_s[1];
      next_pol_known = 1'b0;
      next_rbc = 2'h0;
      next_lcnt = '0;
    end
    else if (act_s[1])
    begin
      next_half = ~half;
      next_lcnt = '0;
      if (!half)
        next_first = ln_s[1];
      else if (first == ln_s[1])
        next_ce = 1'b1;
      else if (!pol_known)
      begin
        next_pol_known = 1'b1;
        next_pol_inv = ~ln_s[1];
        next_pflag = ~ln_s[1];
        next_rsh = {1'b1, rsh[3:1]};
        next_rbc = 2'h1;
      end
      else
      begin
        next_rsh = {rbit, rsh[3:1]};
        next_rbc = rbc + 2'h1;
        if (rbc == 2'h3)
        begin
          next_rnib = {rbit, rsh[3:1]};
          next_rvld = 1'b1;
        end
      end
    end
    else if (ln_s[1] && !ln_d)
      next_lcnt = '0;
  end

  // receive registers, synchroniser pairs first
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ln_s <= 2'h0;
      act_s <= 2'h0;
      ln_d <= 1'b0;
      rin <= 1'b0;
      half <= 1'b0;
      first <= 1'b0;
      pol_inv <= 1'b0;
      pol_known <= 1'b0;
      rbc <= 2'h0;
      rsh <= 4'h0;
      rnib <= 4'h0;
      rvld <= 1'b0;
      ce <= 1'b0;
      pflag <= 1'b0;
      lcnt <= LW'(LINK_FAIL_CYC);
    end
    else
    begin
      ln_s <= {ln_s[0], rx10_line_i};
      act_s <= {act_s[0], rx10_active_i};
      ln_d <= next_ln_d;
      rin <= next_rin;
      half <= next_half;
      first <= next_first;
      pol_inv <= next_pol_inv;
      pol_known <= next_pol_known;
      rbc <= next_rbc;
      rsh <= next_rsh;
      rnib <= next_rnib;
      rvld <= next_rvld;
      ce <= next_ce;
      pflag <= next_pflag;
      lcnt <= next_lcnt;
    end
  end

  assign rx10_nib_o = rnib;
  assign rx10_nib_vld_o = rvld;
  assign rx10_dv_o = rin;
  assign rx10_code_err_o = ce;
  assign polarity_reversed_flag_o = pflag;
  assign rx10_link_o = (lcnt < LW'(LINK_FAIL_CYC));

  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_sync_loss_unlock: assert property (sync_abort |=> !locked && !rx100_dv_o)
    else $error("sync loss did not drop lock");
  a_bypass_passes: assert property (descr_bypass_i |-> dbit == rx100_bit_i)
    else $error("bypass altered data");
  a_ssd_preamble: assert property (ssd_hit |=> rx100_dv_o && rx100_nib_vld_o
    && rx100_nib_o == 4'h5 ##1 rx100_nib_vld_o && rx100_nib_o == 4'h5)
    else $error("start pair did not give two preamble nibbles");
  a_ssd_valid: assert property (!rx100_dv_o && ssd_hit |=> rx100_dv_o && rx100_crs_o)
    else $error("start pair did not raise valid");
  a_end_drops: assert property (end_hit |=> !rx100_dv_o && !rx100_crs_o && !rx100_nib_vld_o)
    else $error("end of stream left valid up");
  a_bad_group_err: assert property (grp_done && st == ecp_pkg::ECP_RX_DATA && !dif.is_data
    && !dif.is_t && !dif.is_idle && !sync_abort |=> rx100_er_o)
    else $error("invalid group gave no error");
  a_t_no_r_err: assert property (grp_done && st == ecp_pkg::ECP_RX_GOT_T && !dif.is_r
    && !sync_abort |=> rx100_er_o)
    else $error("lone end symbol gave no error");
  a_jabber_clear: assert property (!tx_en_i |=> !jabber_o)
    else $error("jabber held after enable drop");
  a_jabber_silent: assert property (jabber_o && $past(jabber_o) |-> !tx10_drive_o)
    else $error("transmit continued in jabber");
  a_rx10_rate: assert property (rx10_nib_vld_o |=> !rx10_nib_vld_o [*7])
    else $error("receive nibbles faster than 2.5 MHz");
  c_frame_end: cover property (end_hit);
  c_sync_loss: cover property (sync_abort);
  c_pol_rev: cover property (polarity_reversed_flag_o);
  c_tx_jabber: cover property (jabber_o);
endmodule
`default_nettype wire

// ==== hdl/ecp_dec_if.sv ====
// ecp_dec_if: code-group lookup between the receive path and its decoder
// assumes the decoder is purely combinational
`timescale 1ns/1ps
`default_nettype none
interface ecp_dec_if;
  logic [4:0] code;
  logic [3:0] nibble;
  logic is_data;
  logic is_idle;
  logic is_t;
  logic is_r;
  modport dec (input code, output nibble, is_data, is_idle, is_t, is_r);
  modport user (output code, input nibble, is_data, is_idle, is_t, is_r);
endinterface
`default_nettype wire

// ==== hdl/ecp_decoder.sv ====
// ecp_decoder: 5-bit code-group to 4-bit nibble lookup
// assumes the code-group is already aligned by the caller
`timescale 1ns/1ps
`default_nettype none
module ecp_decoder (
  // lookup port
  ecp_dec_if.dec dec
);
  // table lookup, data groups only are flagged as data
  always_comb
  begin
    dec.nibble = 4'h0;
    dec.is_data = 1'b1;
    case (dec.code)
      5'h1e: dec.nibble = 4'h0;
      5'h09: dec.nibble = 4'h1;
      5'h14: dec.nibble = 4'h2;
      5'h15: dec.nibble = 4'h3;
      5'h0a: dec.nibble = 4'h4;
      5'h0b: dec.nibble = 4'h5;
      5'h0e: dec.nibble = 4'h6;
      5'h0f: dec.nibble = 4'h7;
      5'h12: dec.nibble = 4'h8;
      5'h13: dec.nibble = 4'h9;
      5'h16: dec.nibble = 4'ha;
      5'h17: dec.nibble = 4'hb;
      5'h1a: dec.nibble = 4'hc;
      5'h1b: dec.nibble = 4'hd;
      5'h1c: dec.nibble = 4'he;
      5'h1d: dec.nibble = 4'hf;
      default: dec.is_data = 1'b0;
    endcase
  end

  // control symbols
  assign dec.is_idle = (dec.code == ecp_pkg::CG_I);
  assign dec.is_t = (dec.code == ecp_pkg::CG_T);
  assign dec.is_r = (dec.code == ecp_pkg::CG_R);
endmodule
`default_nettype wire

// ==== hdl/ecp_pkg.sv ====
// ecp_pkg: constants of the twisted-pair coding path
// assumes a single 20 MHz core clock drives every block that uses it
`default_nettype none
package ecp_pkg;
  // clock and timing
  localparam int CLK_MHZ = 20;
  localparam int SYNC_WIN_NS = 40000;
  localparam int SYNC_WIN_CYC = (SYNC_WIN_NS * CLK_MHZ) / 1000;
  localparam int JABBER_MS = 45;
  localparam int JABBER_CYC = JABBER_MS * CLK_MHZ * 1000;
  localparam int NLP_PERIOD_MS = 16;
  localparam int NLP_PERIOD_CYC = NLP_PERIOD_MS * CLK_MHZ * 1000;
  localparam int NLP_PULSE_NS = 100;
  localparam int NLP_PULSE_CYC = (NLP_PULSE_NS * CLK_MHZ) / 1000;
  localparam int LINK_FAIL_MS = 100;
  localparam int LINK_FAIL_CYC = LINK_FAIL_MS * CLK_MHZ * 1000;
  localparam int TXCLK_DIV = 8;
  // descrambler synchronisation
  localparam int LFSR_W = 11;
  localparam int SYNC_CHECK_BITS = 32;
  localparam int IDLE_RUN_BITS = 10;
  // code-groups
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0d;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [4:0] CG_I = 5'h1f;
  localparam logic [9:0] SSD_PAIR = {CG_J, CG_K};
  localparam logic [3:0] PREAMBLE_NIB = 4'h5;
  // 100 Mb/s frame states
  typedef enum logic [1:0] {ECP_RX_IDLE, ECP_RX_DATA, ECP_RX_GOT_T, ECP_RX_GOT_I} ecp_rx_e;
endpackage
`default_nettype wire

// ==== tb/ecp_mac_model.sv ====
// ecp_mac_model: MAC side of the transmit nibble interface
// assumes tx_clk_i is the block's divided transmit clock, edges on core clock edges
`timescale 1ns/1ps
`default_nettype none
module ecp_mac_model (
  // transmit clock from the block
  input wire logic tx_clk_i,
  // transmit nibble bus
  output logic tx_en_o,
  output logic [3:0] txd_o
);
  // idle bus at time zero
  initial
  begin
    tx_en_o = 1'b0;
    txd_o = 4'ha;
  end
  // present a nibble after one clock rise, held until the capturing rise
  task automatic send(input logic [3:0] nib);
    @(posedge tx_clk_i);
    #2;
    tx_en_o = 1'b1;
    txd_o = nib;
  endtask
  // let the last nibble be captured, then release; stale data is inverted
  task automatic stop();
    @(posedge tx_clk_i);
    #2;
    tx_en_o = 1'b0;
    txd_o = ~txd_o;
  endtask
endmodule
`default_nettype wire

// ==== tb/test_ethernet_phy_digital_coding_path.sv ====
// test_ethernet_phy_digital_coding_path: self-checking bench of the coding path
// assumes short jabber, link pulse and link fail counts set through parameters
`timescale 1ns/1ps
`default_nettype none
module test_ethernet_phy_digital_coding_path;
  localparam int JAB = 200;
  localparam int LFAIL = 200;
  localparam logic [7:0] TXB = 8'h39;
  localparam logic [7:0] RXB = 8'h6d;
  logic clk, rst_n, b100, b100_vld, bypass, tx_en, rx10_line, rx10_act;
  logic [3:0] txd, nib100, nib10;
  logic nib100_vld, dv100, er100, crs100, locked, tx_clk, jabber, tx10_data, tx10_drive;
  logic nib10_vld, dv10, cerr10, pol_flag, link10;
  logic [3:0] q100[$];
  logic [3:0] q10[$];
  int er_n, cerr_n, error_cnt, checked, n;
  // key register of the far-end scrambler, any nonzero start value
  logic [10:0] scr = 11'h4b1;
  // rows of {code-group, nibble it decodes to}
  logic [8:0] rows [16] = '{9'h1e0, 9'h091, 9'h142, 9'h153, 9'h0a4, 9'h0b5, 9'h0e6, 9'h0f7,
    9'h128, 9'h139, 9'h16a, 9'h17b, 9'h1ac, 9'h1bd, 9'h1ce, 9'h1df};
  // 20 MHz core clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // device under test with shortened counts
  ecp_coding_path #(.JABBER_CYC(JAB), .NLP_PERIOD_CYC(40), .LINK_FAIL_CYC(LFAIL)) dut_u (
    .core_clk_i(clk), .rst_n_i(rst_n), .rx100_bit_i(b100), .rx100_bit_vld_i(b100_vld),
    .descr_bypass_i(bypass), .rx100_nib_o(nib100), .rx100_nib_vld_o(nib100_vld),
    .rx100_dv_o(dv100), .rx100_er_o(er100), .rx100_crs_o(crs100), .rx100_locked_o(locked),
    .tx_clk_o(tx_clk), .tx_en_i(tx_en), .txd_i(txd), .jabber_o(jabber),
    .tx10_data_o(tx10_data), .tx10_drive_o(tx10_drive), .rx10_line_i(rx10_line),
    .rx10_active_i(rx10_act), .rx10_nib_o(nib10), .rx10_nib_vld_o(nib10_vld),
    .rx10_dv_o(dv10), .rx10_code_err_o(cerr10), .polarity_reversed_flag_o(pol_flag),
    .rx10_link_o(link10));
  // MAC partner on the transmit nibble bus
  ecp_mac_model mac_u (.tx_clk_i(tx_clk), .tx_en_o(tx_en), .txd_o(txd));
  // collect nibbles and error pulses
  always @(posedge clk)
  begin
    if (nib100_vld === 1'b1)
      q100.push_back(nib100);
    if (er100 === 1'b1)
      er_n++;
    if (nib10_vld === 1'b1)
      q10.push_back(nib10);
    if (cerr10 === 1'b1)
      cerr_n++;
  end
  // value compare
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // count compare
  task automatic chk_cnt(input string what, input int exp, input int got);
    checked++;
    if (got != exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // step k edges, then the drive delay
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  // one code-group, leftmost bit first
  task automatic send_cg(input logic [4:0] cg);
    for (int i = 4; i >= 0; i--)
    begin
      cyc(1);
      b100 = cg[i];
      b100_vld = 1'b1;
    end
  endtask
  // one code-group through the far-end scrambler key, x^11 + x^9 + 1
  task automatic send_scr(input logic [4:0] cg);
    for (int i = 4; i >= 0; i--)
    begin
      scr = {scr[9:0], scr[10] ^ scr[8]};
      cyc(1);
      b100 = cg[i] ^ scr[0];
      b100_vld = 1'b1;
    end
  endtask
  // stop the bit stream
  task automatic end100();
    cyc(1);
    b100_vld = 1'b0;
    b100 = ~b100;
    cyc(3);
  endtask
  // one Manchester bit as {first half, second half}
  task automatic rx10_pair(input logic [1:0] h);
    cyc(1);
    rx10_act = 1'b1;
    rx10_line = h[1];
    cyc(1);
    rx10_line = h[0];
  endtask
  // two-nibble frame, optionally reversed, optionally with a bad bit
  task automatic rx10_frame(input logic rev, input logic bad);
    for (int i = 0; i < 8; i++)
    begin
      if (bad && i == 4)
        rx10_pair(2'b11);
      rx10_pair({~RXB[i], RXB[i]} ^ {rev, rev});
    end
    chk("rx10 valid", 4'h1, {3'b000, dv10});
    cyc(1);
    rx10_act = 1'b0;
    rx10_line = 1'b0;
    cyc(20);
  endtask
  // verdict
  task automatic results();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #(20000 * 50);
    error_cnt++;
    $display("watchdog expired");
    results();
  end
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    {b100, b100_vld, bypass, rx10_line, rx10_act} = 5'h00;
    {er_n, cerr_n, error_cnt, checked} = '0;
    cyc(10);
    chk("reset group a", 4'h0, {dv100, locked, jabber, link10});
    chk("reset group b", 4'h0, {tx_clk, tx10_drive, nib100_vld, pol_flag});
    rst_n = 1'b1;
    $display("test reset done");
    send_cg(ecp_pkg::CG_J);
    send_cg(ecp_pkg::CG_K);
    end100();
    chk("no lock", 4'h0, {2'b00, locked, dv100});
    bypass = 1'b1;
    repeat (4) send_cg(ecp_pkg::CG_I);
    chk("bypass lock", 4'h1, {3'b000, locked});
    send_cg(ecp_pkg::CG_J);
    send_cg(ecp_pkg::CG_K);
    chk("dv before start", 4'h0, {3'b000, dv100});
    foreach (rows[i]) send_cg(rows[i][8:4]);
    chk("dv crs in frame", 4'h3, {2'b00, dv100, crs100});
    send_cg(ecp_pkg::CG_T);
    send_cg(ecp_pkg::CG_R);
    end100();
    chk("dv crs after end", 4'h0, {2'b00, dv100, crs100});
    chk_cnt("nibble count", 18, q100.size());
    chk("preamble a", ecp_pkg::PREAMBLE_NIB, q100[0]);
    chk("preamble b", ecp_pkg::PREAMBLE_NIB, q100[1]);
    foreach (rows[i]) chk("data nibble", rows[i][3:0], q100[i + 2]);
    chk_cnt("errors clean", 0, er_n);
    $display("test decode table done");
    q100.delete();
    send_cg(ecp_pkg::CG_J);
    send_cg(ecp_pkg::CG_K);
    send_cg(5'h0b);
    send_cg(5'h00);
    send_cg(ecp_pkg::CG_T);
    send_cg(5'h0f);
    send_cg(ecp_pkg::CG_I);
    send_cg(ecp_pkg::CG_I);
    end100();
    chk_cnt("bad frame nibbles", 4, q100.size());
    chk("invalid nibble", 4'h0, q100[3]);
    chk_cnt("bad frame errors", 2, er_n);
    chk("dv after idles", 4'h0, {2'b00, dv100, crs100});
    $display("test code errors done");
    bypass = 1'b0;
    q100.delete();
    repeat (12) send_scr(ecp_pkg::CG_I);
    chk("descrambler lock", 4'h1, {3'b000, locked});
    send_scr(ecp_pkg::CG_J);
    send_scr(ecp_pkg::CG_K);
    send_scr(5'h0a);
    send_scr(5'h0a);
    chk("descrambled nibble", 4'h4, q100[2]);
    repeat (170) send_scr(5'h0a);
    chk("dv crs lock after loss", 4'h0, {1'b0, locked, dv100, crs100});
    n = q100.size();
    repeat (4) send_scr(5'h0a);
    chk_cnt("nibbles after loss", n, q100.size());
    end100();
    $display("test descrambler done");
    chk("link down", 4'h0, {3'b000, link10});
    rx10_line = 1'b1;
    cyc(2);
    rx10_line = 1'b0;
    cyc(6);
    chk("link up", 4'h1, {3'b000, link10});
    cyc(LFAIL + 20);
    chk("link lost", 4'h0, {3'b000, link10});
    $display("test link pulses done");
    fork
      begin
        mac_u.send(TXB[3:0]);
        mac_u.send(TXB[7:4]);
        mac_u.stop();
      end
      begin
        @(posedge tx_clk);
        @(posedge tx_clk);
        for (int i = 0; i < 16; i++)
        begin
          cyc(1);
          chk("line half", {2'b00, 1'b1, TXB[i / 2] ^ ~i[0]}, {2'b00, tx10_drive, tx10_data});
        end
      end
    join
    $display("test transmit done");
    n = 0;
    while (tx10_drive !== 1'b0 && n < 60)
    begin
      cyc(1);
      n++;
    end
    while (tx10_drive !== 1'b1 && n < 120)
    begin
      cyc(1);
      n++;
    end
    chk("link pulse start", 4'h3, {2'b00, tx10_drive, tx10_data});
    cyc(1);
    chk("link pulse second", 4'h3, {2'b00, tx10_drive, tx10_data});
    cyc(1);
    chk("link pulse end", 4'h0, {3'b000, tx10_drive});
    $display("test idle pulses done");
    fork
      begin
        repeat (40) mac_u.send(4'hf);
        mac_u.stop();
      end
      begin
        n = 0;
        while (jabber !== 1'b1 && n < 400)
        begin
          cyc(1);
          n++;
        end
        chk_cnt("jabber delay in range", 1, int'(n >= JAB && n <= JAB + 10));
        cyc(2);
        chk("jabber line", 4'h2, {2'b00, jabber, tx10_drive});
      end
    join
    cyc(2);
    chk("jabber cleared", 4'h0, {3'b000, jabber});
    $display("test jabber done");
    rx10_frame(1'b0, 1'b1);
    chk_cnt("rx10 count", 2, q10.size());
    chk("rx10 first", RXB[3:0], q10[0]);
    chk("rx10 second", RXB[7:4], q10[1]);
    chk_cnt("manchester errors", 1, cerr_n);
    chk("polarity normal", 4'h0, {2'b00, dv10, pol_flag});
    q10.delete();
    cerr_n = 0;
    rx10_frame(1'b1, 1'b0);
    chk_cnt("reversed count", 2, q10.size());
    chk("reversed first", RXB[3:0], q10[0]);
    chk("reversed second", RXB[7:4], q10[1]);
    chk("polarity reversed", 4'h1, {3'b000, pol_flag});
    $display("test ten meg receive done");
    results();
  end
endmodule
`default_nettype wire
